// >>> hdl/ecm_map.svh
// offsets, field positions and constants of the channel monitor bank
`ifndef ECM_MAP_SVH
`define ECM_MAP_SVH

// ************************************************************
// register word indices (byte address is four times the index)
// ************************************************************
`define ECM_IDX_SEND_IN_LVL    6'h1E
`define ECM_IDX_SEND_OUT_LVL   6'h1F
`define ECM_IDX_RECV_IN_LVL    6'h20
`define ECM_IDX_SEND_IN_OFS    6'h21
`define ECM_IDX_SEND_OUT_OFS   6'h22
`define ECM_IDX_ECHO_LVL       6'h23
`define ECM_IDX_NOISE_LVL      6'h24
`define ECM_IDX_RET_LOSS       6'h25
`define ECM_IDX_COMB_LOSS      6'h26
`define ECM_IDX_SUPPR_THR      6'h27
`define ECM_IDX_OVC_HANG       6'h28
`define ECM_IDX_SEND_IN_SMP    6'h29
`define ECM_IDX_SEND_OUT_SMP   6'h2A
`define ECM_IDX_RECV_IN_SMP    6'h2B
`define ECM_IDX_STATE1         6'h2C
`define ECM_IDX_STATE2         6'h2D
`define ECM_IDX_STATE3         6'h2E
`define ECM_IDX_MON_CTL        6'h30
`define ECM_IDX_FLEX_CFG       6'h31

// ************************************************************
// fields, reset values and scale constants
// ************************************************************
`define ECM_CTL_RESET          5'h00
`define ECM_FLEX_RESET         8'h00
`define ECM_FLEX_A_SEL_LSB     0
`define ECM_FLEX_A_EN_BIT      3
`define ECM_FLEX_B_SEL_LSB     4
`define ECM_FLEX_B_EN_BIT      7
`define ECM_LVL_MAX            8'hBF
`define ECM_LVL_ZERO_DBM0      8'hB8
`define ECM_LVL_STEP_6DB       8'h10
`define ECM_LVL_SILENCE        8'h00
`define ECM_RESP_OKAY          2'h0
`define ECM_RESP_SLVERR        2'h2
`define ECM_NCHAN              32

`endif

// >>> hdl/ecm_pkg.sv
// types shared by the channel monitor bank
package ecm_pkg;

    typedef logic [4:0] ecm_chan_t;
    typedef logic [5:0] ecm_idx_t;

    // first state word, bit 7 first
    typedef struct packed {
        logic no_voice_flag;
        logic answer_tone_unprotected_flag;
        logic answer_tone_flag;
        logic answer_tone_phase_rev_flag;
        logic coef_reset_flag;
        logic coef_frozen_flag;
        logic suppressor_active_flag;
        logic path_bypass_flag;
    } ecm_state1_s;

    typedef struct packed {
        logic subtractor_bypass_flag;
        logic doubletalk_flag;
        logic fast_conv_flag; // RL15
        logic conv_stability_flag; // RL15
        logic cc_tone_unprotected_flag; // RL16
        logic cc_tone_level2_flag; // RL16
        logic cc_tone_level1_flag; // RL16
        logic idle_channel_flag; // RL15
    } ecm_state2_s;

    typedef struct packed {
        logic cas_disable_flag;
        logic user_ctl_disable_flag;
        logic user_ctl_fixed_flag;
        logic serial_disable_flag;
        logic serial_suppr_off_flag;
        logic serial_hold_flag;
        logic serial_conv_off_flag;
        logic serial_flex_ctl_flag;
    } ecm_state3_s;

    // one channel's monitor snapshot as delivered by the canceller core
    typedef struct packed {
        logic [7:0]  send_in_level;
        logic [7:0]  send_out_level;
        logic [7:0]  recv_in_level;
        logic [5:0]  send_in_offset;
        logic [5:0]  send_out_offset;
        logic [7:0]  echo_level;
        logic [6:0]  noise_level;
        logic [7:0]  return_loss;
        logic [7:0]  combined_loss;
        logic [7:0]  suppr_threshold;
        logic [3:0]  overcomp_eval;
        logic [3:0]  doubletalk_hangover;
        logic [7:0]  send_in_sample;
        logic [7:0]  send_out_sample;
        logic [7:0]  recv_in_sample;
        ecm_state1_s state1;
        ecm_state2_s state2;
        ecm_state3_s state3;
    } ecm_mon_s;

endpackage

// >>> hdl/ecm_mon_mem.sv
// per-channel snapshot store with a registered read port
`timescale 1ns/100ps

module ecm_mon_mem #(
    parameter int DW    = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          clk_i,    // core clock
    input  wire logic          rst_n_i,  // async reset, active low
    input  wire logic          we_i,     // write strobe
    input  wire logic [AW-1:0] waddr_i,  // write channel
    input  wire logic [DW-1:0] wdata_i,  // write data
    input  wire logic [AW-1:0] raddr_i,  // read channel
    output logic      [DW-1:0] rdata_o   // registered read data
);

    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_r;

    // array is not reset: a channel reads unknown until first update
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[raddr_i];
        end
    end

    assign rdata_o = rdata_r;

endmodule

// >>> hdl/ecm_flex_pick.sv
// picks one bit of a status word onto a registered monitor pin
`timescale 1ns/100ps

module ecm_flex_pick #(
    parameter int W  = 8,
    parameter int SW = 3
) (
    input  wire logic          clk_i,    // core clock
    input  wire logic          rst_n_i,  // async reset, active low
    input  wire logic [W-1:0]  word_i,   // status word
    input  wire logic [SW-1:0] sel_i,    // bit position
    input  wire logic          en_i,     // drive enable
    output logic               pin_o     // registered pin level
);

    logic pin_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= en_i & word_i[sel_i];
        end
    end

    assign pin_o = pin_r;

endmodule

// >>> hdl/ecm_regs.sv
// channel monitor register bank of the echo canceller, AXI4-Lite slave
// Operation
// RL1: selected channel samples in three read registers
// RL2: level code 191 means plus 3 dBm0
// RL3: sixteen codes per 6 dB level step
// RL4: 184 is 0 dBm0, 0 is silence
// RL5: send input level as 8-bit log code
// RL6: other levels and losses as log codes
// RL7: suppressor threshold as 8-bit log code
// RL8: noise level is 7 bits, top bit unused
// RL9: offsets are 6-bit ones' complement values
// RL10: overcompensation high nibble, hang-over low nibble
// RL11: state word one tone and voice flags
// RL12: state word one coefficient and bypass flags
// RL13: state word two bit 7 subtractor bypass
// RL14: state word two bit 6 double talk
// RL15: fast convergence, stability protection, idle channel
// RL16: continuity tone flags in bits 3..1
// RL17: any state word two bit to pins
// RL18: state word three disable and fixed flags
// RL19: state word three serial control flags
// RL20: readings follow the selected channel number
// RL21: software clears update interrupt after reading; this bank has no update interrupt, a snapshot only updates the store
// RL22: monitor registers read-only, reads change nothing
// RL23: unused offset, noise, state bits read zero
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "ecm_map.svh"

module ecm_regs #(
    parameter int NCHAN = `ECM_NCHAN
) (
    input  wire logic             CORE_CLK_I,   // core clock, 50 MHz
    input  wire logic             RST_N_I,      // async reset, active low
    input  wire logic [7:0]       AWADDR_I,     // write address
    input  wire logic             AWVALID_I,    // write address valid
    output logic                  AWREADY_O,    // write address ready
    input  wire logic [31:0]      WDATA_I,      // write data
    input  wire logic [3:0]       WSTRB_I,      // write byte enables
    input  wire logic             WVALID_I,     // write data valid
    output logic                  WREADY_O,     // write data ready
    output logic [1:0]            BRESP_O,      // write response
    output logic                  BVALID_O,     // write response valid
    input  wire logic             BREADY_I,     // write response ready
    input  wire logic [7:0]       ARADDR_I,     // read address
    input  wire logic             ARVALID_I,    // read address valid
    output logic                  ARREADY_O,    // read address ready
    output logic [31:0]           RDATA_O,      // read data
    output logic [1:0]            RRESP_O,      // read response
    output logic                  RVALID_O,     // read data valid
    input  wire logic             RREADY_I,     // read data ready
    input  wire logic             UPD_VALID_I,  // core snapshot strobe
    input  wire ecm_pkg::ecm_chan_t UPD_CHAN_I, // channel of snapshot
    input  wire ecm_pkg::ecm_mon_s  UPD_DATA_I, // snapshot contents
    output logic                  FLEX_MON_A_O, // flex monitor pin a
    output logic                  FLEX_MON_B_O  // flex monitor pin b
);
    import ecm_pkg::*;

    // ************************************************************
    // control registers
    // ************************************************************
    ecm_chan_t   sel_r;
    logic [7:0]  flex_cfg_r;
    ecm_mon_s    mem_q;
    ecm_mon_s    view;

    // ************************************************************
    // write channel
    // ************************************************************
    logic        aw_hold_r;
    logic        w_hold_r;
    logic        aw_hold_nxt;
    logic        w_hold_nxt;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    ecm_idx_t    wr_idx_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        do_write;
    logic        wr_ok;

    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
        end else begin
            if (AWVALID_I & awready_r) begin
                aw_hold_nxt = 1'b1;
            end
            if (WVALID_I & wready_r) begin
                w_hold_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awready_r <= ~aw_hold_nxt;
            wready_r  <= ~w_hold_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_idx_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else begin
            if (AWVALID_I & awready_r) begin
                wr_idx_r <= AWADDR_I[7:2];
            end
            if (WVALID_I & wready_r) begin
                wdata_r <= WDATA_I;
                wstrb_r <= WSTRB_I;
            end
        end
    end

    // monitor words accept a write harmlessly, the two control words store it; anything else unmapped
    always_comb begin
        wr_ok = (wr_idx_r >= `ECM_IDX_SEND_IN_LVL &&
                 wr_idx_r <= `ECM_IDX_STATE3) ||
                wr_idx_r == `ECM_IDX_MON_CTL ||
                wr_idx_r == `ECM_IDX_FLEX_CFG;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `ECM_RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? `ECM_RESP_OKAY : `ECM_RESP_SLVERR;
        end else if (BREADY_I) begin
            bvalid_r <= 1'b0;
        end
    end

    // only the two control words store; monitor words drop the data
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_r      <= `ECM_CTL_RESET;
            flex_cfg_r <= `ECM_FLEX_RESET;
        end else if (do_write & wstrb_r[0]) begin // RL22
            if (wr_idx_r == `ECM_IDX_MON_CTL) begin
                sel_r <= wdata_r[4:0]; // RL20
            end
            if (wr_idx_r == `ECM_IDX_FLEX_CFG) begin
                flex_cfg_r <= wdata_r[7:0]; // RL17
            end
        end
    end

    // ************************************************************
    // snapshot store, read at the selected channel
    // ************************************************************
    ecm_mon_mem #(
        .DW    ($bits(ecm_mon_s)),
        .DEPTH (NCHAN),
        .AW    ($bits(ecm_chan_t))
    ) u_mem (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .we_i    (UPD_VALID_I),
        .waddr_i (UPD_CHAN_I),
        .wdata_i (UPD_DATA_I),
        .raddr_i (sel_r), // RL20
        .rdata_o (mem_q)
    );

    // codes above the top of the scale cannot be valid readings
    function automatic logic [7:0] lvl_sat(input logic [7:0] c);
        lvl_sat = (c > `ECM_LVL_MAX) ? `ECM_LVL_MAX : c;
    endfunction

    // zero passes through untouched: it is the silence code
    always_comb begin
        view                 = mem_q;
        view.send_in_level   = lvl_sat(mem_q.send_in_level); // RL5 RL2 RL4
        view.send_out_level  = lvl_sat(mem_q.send_out_level); // RL6 RL3
        view.recv_in_level   = lvl_sat(mem_q.recv_in_level); // RL6
        view.echo_level      = lvl_sat(mem_q.echo_level); // RL6
        view.return_loss     = lvl_sat(mem_q.return_loss); // RL6
        view.combined_loss   = lvl_sat(mem_q.combined_loss); // RL6
        view.suppr_threshold = lvl_sat(mem_q.suppr_threshold); // RL7
    end

    // ************************************************************
    // read channel
    // ************************************************************
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_mux;
    logic        rd_ok;
    logic        ar_take;
    ecm_idx_t    ar_idx;
    ecm_idx_t    rd_idx_r;

    assign ar_take = ARVALID_I & arready_r;
    assign ar_idx  = ARADDR_I[7:2];

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (ar_idx)
            `ECM_IDX_SEND_IN_LVL:  rd_mux[7:0] = view.send_in_level; // RL5
            `ECM_IDX_SEND_OUT_LVL: rd_mux[7:0] = view.send_out_level; // RL6
            `ECM_IDX_RECV_IN_LVL:  rd_mux[7:0] = view.recv_in_level; // RL6
            `ECM_IDX_SEND_IN_OFS:  rd_mux[5:0] = view.send_in_offset; // RL9
            `ECM_IDX_SEND_OUT_OFS: rd_mux[5:0] = view.send_out_offset; // RL9
            `ECM_IDX_ECHO_LVL:     rd_mux[7:0] = view.echo_level; // RL6
            `ECM_IDX_NOISE_LVL:    rd_mux[6:0] = view.noise_level; // RL8
            `ECM_IDX_RET_LOSS:     rd_mux[7:0] = view.return_loss; // RL6
            `ECM_IDX_COMB_LOSS:    rd_mux[7:0] = view.combined_loss; // RL6
            `ECM_IDX_SUPPR_THR:    rd_mux[7:0] = view.suppr_threshold; // RL7
            `ECM_IDX_OVC_HANG: begin
                rd_mux[7:4] = view.overcomp_eval; // RL10
                rd_mux[3:0] = view.doubletalk_hangover; // RL10
            end
            `ECM_IDX_SEND_IN_SMP:  rd_mux[7:0] = view.send_in_sample; // RL1
            `ECM_IDX_SEND_OUT_SMP: rd_mux[7:0] = view.send_out_sample; // RL1
            `ECM_IDX_RECV_IN_SMP:  rd_mux[7:0] = view.recv_in_sample; // RL1
            `ECM_IDX_STATE1:       rd_mux[7:0] = view.state1; // RL11 RL12
            `ECM_IDX_STATE2:       rd_mux[7:0] = view.state2; // RL13 RL14
            `ECM_IDX_STATE3:       rd_mux[7:0] = view.state3; // RL18 RL19
            `ECM_IDX_MON_CTL:      rd_mux[4:0] = sel_r;
            `ECM_IDX_FLEX_CFG:     rd_mux[7:0] = flex_cfg_r;
            default:               rd_ok = 1'b0;
        endcase
    end

    // reading is pure observation: nothing here feeds back into state
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `ECM_RESP_OKAY;
            rd_idx_r  <= '0;
        end else begin
            arready_r <= ~(ar_take | (rvalid_r & ~RREADY_I));
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux; // RL22 RL23
                rresp_r  <= rd_ok ? `ECM_RESP_OKAY : `ECM_RESP_SLVERR;
                rd_idx_r <= ar_idx;
            end else if (RREADY_I) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // flex monitor pins
    // ************************************************************
    ecm_flex_pick #(.W(8), .SW(3)) u_flex_a (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .word_i  (mem_q.state2), // RL17
        .sel_i   (flex_cfg_r[`ECM_FLEX_A_SEL_LSB +: 3]),
        .en_i    (flex_cfg_r[`ECM_FLEX_A_EN_BIT]),
        .pin_o   (FLEX_MON_A_O)
    );

    ecm_flex_pick #(.W(8), .SW(3)) u_flex_b (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .word_i  (mem_q.state2), // RL17
        .sel_i   (flex_cfg_r[`ECM_FLEX_B_SEL_LSB +: 3]),
        .en_i    (flex_cfg_r[`ECM_FLEX_B_EN_BIT]),
        .pin_o   (FLEX_MON_B_O)
    );

    assign AWREADY_O = awready_r;
    assign WREADY_O  = wready_r;
    assign BVALID_O  = bvalid_r;
    assign BRESP_O   = bresp_r;
    assign ARREADY_O = arready_r;
    assign RVALID_O  = rvalid_r;
    assign RDATA_O   = rdata_r;
    assign RRESP_O   = rresp_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_sample_read;
        ar_take && ar_idx == `ECM_IDX_SEND_IN_SMP
            |=> RVALID_O && RDATA_O == {24'h00_0000, $past(mem_q[47:40])};
    endproperty
    a_sample_read: assert property (p_sample_read) // RL1
        else $error("sample read does not match stored code");

    property p_level_ceiling;
        RVALID_O && rd_idx_r >= `ECM_IDX_SEND_IN_LVL &&
            rd_idx_r <= `ECM_IDX_RECV_IN_LVL |-> RDATA_O[7:0] <= 8'hBF;
    endproperty
    a_level_ceiling: assert property (p_level_ceiling) // RL2
        else $error("level code above top of scale");

    property p_silence_kept;
        ar_take && ar_idx == `ECM_IDX_SEND_IN_LVL &&
            mem_q.send_in_level == 8'h00 |=> RDATA_O == 32'h0000_0000;
    endproperty
    a_silence_kept: assert property (p_silence_kept) // RL4
        else $error("silence code altered");

    property p_noise_top_zero;
        RVALID_O && rd_idx_r == `ECM_IDX_NOISE_LVL
            |-> RDATA_O[31:7] == 25'h000_0000;
    endproperty
    a_noise_top_zero: assert property (p_noise_top_zero) // RL8
        else $error("noise level unused bits not zero");

    property p_offset_top_zero;
        RVALID_O && (rd_idx_r == `ECM_IDX_SEND_IN_OFS ||
            rd_idx_r == `ECM_IDX_SEND_OUT_OFS) |-> RDATA_O[31:6] == '0;
    endproperty
    a_offset_top_zero: assert property (p_offset_top_zero) // RL9
        else $error("offset unused bits not zero");

    property p_nibbles;
        ar_take && ar_idx == `ECM_IDX_OVC_HANG |=>
            RDATA_O[7:4] == $past(mem_q.overcomp_eval) &&
            RDATA_O[3:0] == $past(mem_q.doubletalk_hangover);
    endproperty
    a_nibbles: assert property (p_nibbles) // RL10
        else $error("overcompensation or hang-over nibble wrong");

    property p_flex_a;
        ##1 FLEX_MON_A_O == ($past(flex_cfg_r[3]) &&
            $past(mem_q.state2[flex_cfg_r[2:0]]));
    endproperty
    a_flex_a: assert property (p_flex_a) // RL17
        else $error("flex pin a does not follow chosen bit");

    property p_follow_channel;
        UPD_VALID_I && UPD_CHAN_I == sel_r && $stable(sel_r)
            ##1 $stable(sel_r) |-> ##1 mem_q == $past(UPD_DATA_I, 2);
    endproperty
    a_follow_channel: assert property (p_follow_channel) // RL20
        else $error("selected channel snapshot not shown");

    property p_ro_write;
        do_write && wr_idx_r <= `ECM_IDX_STATE3 &&
            wr_idx_r >= `ECM_IDX_SEND_IN_LVL
            |=> $stable(sel_r) && $stable(flex_cfg_r) &&
                BRESP_O == `ECM_RESP_OKAY;
    endproperty
    a_ro_write: assert property (p_ro_write) // RL22
        else $error("write to monitor word had an effect");

    c_state2_read: cover property (ar_take && ar_idx == `ECM_IDX_STATE2);
    c_flex_high:   cover property (FLEX_MON_A_O ##1 FLEX_MON_B_O);
    c_sel_write:   cover property (do_write &&
                                   wr_idx_r == `ECM_IDX_MON_CTL);

endmodule

// >>> testbench/ecm_tb.sv
// self-checking bench for the channel monitor register bank
`timescale 1ns/100ps
`include "ecm_map.svh"

module testbench;
    import ecm_pkg::*;
    logic        clk, rst_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        upd_valid, flex_a, flex_b;
    ecm_chan_t   upd_chan;
    ecm_mon_s    upd_data, m, m2;
    logic [31:0] d;
    logic [1:0]  r;
    int          n_fail, total_checks;
    logic [7:0]  exp_t [17] = '{8'hBF, 8'hB8, 8'h01, 8'h2A, 8'h15, 8'h00,
        8'h7F, 8'hBF, 8'h10, 8'hBF, 8'hA5, 8'hD5, 8'h2A, 8'h80, 8'hA5,
        8'h81, 8'h3C};

    ecm_regs DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
        .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
        .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
        .RREADY_I(rready), .UPD_VALID_I(upd_valid), .UPD_CHAN_I(upd_chan),
        .UPD_DATA_I(upd_data), .FLEX_MON_A_O(flex_a),
        .FLEX_MON_B_O(flex_b));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic guard(input int n);
        if (n >= 50) begin
            n_fail++;
            close_out();
        end
    endtask

    // bready and rready stay high, so each answer is taken when first seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        guard(n);
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        guard(n);
        d = rdata;
        r = rresp;
    endtask

    task automatic upd(input ecm_chan_t c, input ecm_mon_s v);
        upd_valid <= 1'b1;
        upd_chan <= c;
        upd_data <= v;
        @(posedge clk);
        upd_valid <= 1'b0;
        @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_ctl();
        chk("idle handshake", {27'h0, awready, wready, arready, bvalid,
            rvalid}, 32'h1C);
        rd(8'hC0); chk("ctl reset", d, 32'h0);
        rd(8'hC4); chk("flex reset", d, 32'h0);
        wr(8'hC0, 32'h3, 4'hF, `ECM_RESP_OKAY);
        wr(8'hC0, 32'h5, 4'h0, `ECM_RESP_OKAY);
        rd(8'hC0); chk("ctl strobe", d, 32'h3);
    endtask

    task automatic t_snap();
        upd(5'h03, m);
        upd(5'h05, m2);
        for (int i = 0; i < 17; i++) begin
            rd(8'h78 + 8'(4 * i));
            chk("mon word", d, {24'h0, exp_t[i]});
            chk("mon resp", 32'(r), 32'(`ECM_RESP_OKAY));
        end
    endtask

    // noise and offset words above check their unused top bits too
    task automatic t_ro();
        wr(8'hB4, 32'hFF, 4'hF, `ECM_RESP_OKAY);
        rd(8'hB4); chk("ro word", d, 32'h81);
        rd(8'h00); chk("unmapped", d, 32'h0);
        chk("unmapped resp", 32'(r), 32'(`ECM_RESP_SLVERR));
        wr(8'hFC, 32'h1, 4'hF, `ECM_RESP_SLVERR);
    endtask

    task automatic t_sel_flex();
        wr(8'hC0, 32'h5, 4'hF, `ECM_RESP_OKAY);
        repeat (2) @(posedge clk);
        rd(8'hA4); chk("sel sample", d, 32'h3C);
        rd(8'hB4); chk("sel state2", d, 32'h42);
        rd(8'h78); chk("silence", d, 32'h0);
        wr(8'hC4, 32'hFE, 4'hF, `ECM_RESP_OKAY);
        repeat (4) @(posedge clk);
        chk("flex a", 32'(flex_a), 32'h1);
        chk("flex b", 32'(flex_b), 32'h0);
        wr(8'hC4, 32'h96, 4'hF, `ECM_RESP_OKAY);
        repeat (4) @(posedge clk);
        chk("flex a off", 32'(flex_a), 32'h0);
        chk("flex b", 32'(flex_b), 32'h1);
    endtask

    initial begin
        n_fail = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, arvalid, upd_valid} = '0;
        bready = 1'b1;
        rready = 1'b1;
        upd_chan = '0;
        upd_data = '0;
        m = '{8'hC8, 8'hB8, 8'h01, 6'h2A, 6'h15, 8'h00, 7'h7F, 8'hBF,
              8'h10, 8'hC0, 4'hA, 4'h5, 8'hD5, 8'h2A, 8'h80, 8'hA5,
              8'h81, 8'h3C};
        m2 = m;
        m2.send_in_sample = 8'h3C;
        m2.state2 = 8'h42;
        m2.send_in_level = 8'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_ctl();
        t_snap();
        t_ro();
        t_sel_flex();
        close_out();
    end
endmodule
